/* rtl/ssr_top.sv */
/*
 * Clocked half-duplex serial port: master or slave reception and
 * transmission, behind an AXI4-Lite register slave.
 * Assumes the shift clock and data pins are resolved outside from
 * the out/enable pairs; pin inputs are asynchronous to aclk.
 */
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps

module ssr_top
    import ssr_pkg::*;
(
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         ce,
    input  wire ssr_axi_req_t axi_req,
    output ssr_axi_rsp_t      axi_rsp,
    input  wire logic         shift_clk_pin_in,
    input  wire logic         serial_data_pin_in,
    output ssr_pin_t          pins,
    output logic              irq
);

    ssr_state_t s;
    ssr_state_t n;

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    always_comb begin
        logic [15:0] div;
        logic        rx_en;
        logic        tx_act;
        logic        fall;
        logic        ck_lvl;
        logic [8:0]  word;
        logic [3:0]  last_rx;
        logic [3:0]  last_tx;
        logic [7:0]  d;
        logic [7:0]  rd;
        logic        hit;
        logic        wr_tx;
        div     = '0;
        rx_en   = 1'b0;
        tx_act  = 1'b0;
        fall    = 1'b0;
        ck_lvl  = 1'b0;
        word    = '0;
        last_rx = LAST_BIT_EIGHT;
        last_tx = LAST_BIT_EIGHT;
        d       = s.w_data;
        rd      = '0;
        hit     = 1'b0;
        wr_tx   = 1'b0;
        n       = s;

        // ----------------------------------------------------------
        // Pin synchronisers
        // ----------------------------------------------------------
        n.ck_s1 = shift_clk_pin_in;
        n.ck_s2 = s.ck_s1;
        n.dt_s1 = serial_data_pin_in;
        n.dt_s2 = s.dt_s1;

        // ----------------------------------------------------------
        // Bus write: address and data taken in either order
        // ----------------------------------------------------------
        if (axi_req.awvalid && s.rsp.awready) begin
            n.aw_got  = 1'b1;
            n.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && s.rsp.wready) begin
            n.w_got  = 1'b1;
            n.w_data = axi_req.wdata[7:0];
            n.w_lane = axi_req.wstrb[0];
        end
        if (s.rsp.bvalid && axi_req.bready) begin
            n.rsp.bvalid = 1'b0;
        end
        if (s.aw_got && s.w_got) begin
            hit = 1'b1;
            unique case (s.aw_addr[7:2])
                ADDR_RECEIVE_STATUS_CONTROL[7:2]: begin
                    if (s.w_lane) begin
                        n.serial_port_enable = d[BIT_PORT_ENABLE];
                        n.rx9  = d[BIT_NINE_RX];
                        n.single_receive_enable = d[BIT_SINGLE_RX];
                        n.continuous_receive_enable = d[BIT_CONT_RX];
                        if (s.continuous_receive_enable && !d[BIT_CONT_RX]) begin
                            n.overrun_error = 1'b0;
                        end
                    end
                end
                ADDR_TRANSMIT_STATUS_CONTROL[7:2]: begin
                    if (s.w_lane) begin
                        n.clock_source_select = d[BIT_CLOCK_SOURCE];
                        n.tx9  = d[BIT_NINE_TX];
                        n.transmit_enable = d[BIT_TX_ENABLE];
                        n.sync = d[BIT_SYNC_MODE];
                        n.transmit_ninth_bit = d[BIT_TX_NINTH];
                    end
                end
                ADDR_BAUD_CONTROL[7:2]: begin
                    if (s.w_lane) begin
                        n.shift_clk_polarity  = d[BIT_CLK_POLARITY];
                        n.wide_divisor_select = d[BIT_WIDE_DIVISOR];
                    end
                end
                ADDR_BAUD_DIVISOR_HIGH[7:2]: begin
                    if (s.w_lane) begin
                        n.div_hi = d;
                    end
                end
                ADDR_BAUD_DIVISOR_LOW[7:2]: begin
                    if (s.w_lane) begin
                        n.div_lo = d;
                    end
                end
                ADDR_TRANSMIT_BUFFER[7:2]: begin
                    if (s.w_lane) begin
                        n.tx_buf  = d;
                        n.tx_full = 1'b1;
                        wr_tx     = 1'b1;
                    end
                end
                ADDR_IRQ_ENABLES_ONE[7:2]: begin
                    if (s.w_lane) begin
                        n.ena = d;
                    end
                end
                ADDR_IRQ_PRIORITY_ONE[7:2]: begin
                    if (s.w_lane) begin
                        n.pri = d;
                    end
                end
                ADDR_CORE_INTERRUPT_CONTROL[7:2]: begin
                    if (s.w_lane) begin
                        n.core = d;
                    end
                end
                // Flags and receive buffer ignore writes
                ADDR_RECEIVE_BUFFER[7:2],
                ADDR_IRQ_FLAGS_ONE[7:2]: begin
                    hit = 1'b1;
                end
                default: begin
                    hit = 1'b0;
                end
            endcase
            n.aw_got     = 1'b0;
            n.w_got      = 1'b0;
            n.rsp.bvalid = 1'b1;
            n.rsp.bresp  = hit ? RESP_OKAY : RESP_SLVERR;
        end
        n.rsp.awready = !n.aw_got && !n.rsp.bvalid;
        n.rsp.wready  = !n.w_got && !n.rsp.bvalid;

        // ----------------------------------------------------------
        // Bus read
        // ----------------------------------------------------------
        if (s.rsp.rvalid && axi_req.rready) begin
            n.rsp.rvalid = 1'b0;
        end
        if (axi_req.arvalid && s.rsp.arready) begin
            hit = 1'b1;
            unique case (axi_req.araddr[7:2])
                ADDR_RECEIVE_STATUS_CONTROL[7:2]: begin
                    rd[BIT_PORT_ENABLE]   = s.serial_port_enable;
                    rd[BIT_NINE_RX]       = s.rx9;
                    rd[BIT_SINGLE_RX]     = s.single_receive_enable;
                    rd[BIT_CONT_RX]       = s.continuous_receive_enable;
                    rd[BIT_FRAMING_ERROR] = 1'b0;
                    rd[BIT_OVERRUN_ERROR] = s.overrun_error;
                    rd[BIT_RX_NINTH]      = s.received_ninth_bit;
                end
                ADDR_RECEIVE_BUFFER[7:2]: begin
                    rd        = s.rx_buf;
                    n.rx_full = 1'b0;
                end
                ADDR_TRANSMIT_STATUS_CONTROL[7:2]: begin
                    rd[BIT_CLOCK_SOURCE]  = s.clock_source_select;
                    rd[BIT_NINE_TX]       = s.tx9;
                    rd[BIT_TX_ENABLE]     = s.transmit_enable;
                    rd[BIT_SYNC_MODE]     = s.sync;
                    rd[BIT_SHIFTER_EMPTY] = !s.tx_busy;
                    rd[BIT_TX_NINTH]      = s.transmit_ninth_bit;
                end
                ADDR_BAUD_CONTROL[7:2]: begin
                    rd[BIT_CLK_POLARITY] = s.shift_clk_polarity;
                    rd[BIT_WIDE_DIVISOR] = s.wide_divisor_select;
                end
                ADDR_BAUD_DIVISOR_HIGH[7:2]: begin
                    rd = s.div_hi;
                end
                ADDR_BAUD_DIVISOR_LOW[7:2]: begin
                    rd = s.div_lo;
                end
                ADDR_TRANSMIT_BUFFER[7:2]: begin
                    rd = s.tx_buf;
                end
                ADDR_IRQ_FLAGS_ONE[7:2]: begin
                    rd[BIT_RX_IRQ] = s.rx_full;
                    rd[BIT_TX_IRQ] = !s.tx_full;
                end
                ADDR_IRQ_ENABLES_ONE[7:2]: begin
                    rd = s.ena;
                end
                ADDR_IRQ_PRIORITY_ONE[7:2]: begin
                    rd = s.pri;
                end
                ADDR_CORE_INTERRUPT_CONTROL[7:2]: begin
                    rd = s.core;
                end
                default: begin
                    hit = 1'b0;
                end
            endcase
            n.rsp.rvalid = 1'b1;
            n.rsp.rdata  = {24'h000000, rd};
            n.rsp.rresp  = hit ? RESP_OKAY : RESP_SLVERR;
        end
        n.rsp.arready = !n.rsp.rvalid;

        // ----------------------------------------------------------
        // Shift clock: own divider as master, pin edges as slave
        // ----------------------------------------------------------
        rx_en = s.serial_port_enable && s.sync && !s.overrun_error
                && (s.continuous_receive_enable || (s.single_receive_enable && s.clock_source_select));
        tx_act = s.serial_port_enable && s.sync && s.transmit_enable
                 && !(s.continuous_receive_enable || s.single_receive_enable);
        div = s.wide_divisor_select ? {s.div_hi, s.div_lo} : {8'h00, s.div_lo};
        ck_lvl = s.ck_s2 ^ s.shift_clk_polarity;
        n.ck_prev = ck_lvl;
        if (s.clock_source_select) begin
            if (!(rx_en || s.tx_busy)) begin
                n.bcnt = div;
                n.ick  = 1'b0;
            end else if (s.bcnt == 16'h0000) begin
                n.bcnt = div;
                n.ick  = !s.ick;
                fall   = s.ick;
            end else begin
                n.bcnt = s.bcnt - 16'h0001;
            end
        end else begin
            // Pin edges pass the aclk synchronisers and ce-gated state, so ce low stops it too
            n.bcnt = div;
            n.ick  = 1'b0;
            fall   = s.ck_prev && !ck_lvl;
        end

        // ----------------------------------------------------------
        // Receiver
        // ----------------------------------------------------------
        last_rx = s.rx9 ? LAST_BIT_NINE : LAST_BIT_EIGHT;
        word    = {s.dt_s2, s.rx_sh[8:1]};
        if (!rx_en) begin
            n.rx_cnt = 4'h0;
        end else if (fall) begin
            n.rx_sh  = word;
            n.rx_cnt = s.rx_cnt + 4'h1;
            if (s.rx_cnt == last_rx) begin
                n.rx_cnt = 4'h0;
                // Full buffer: drop word, hold error until cleared
                if (s.rx_full && n.rx_full) begin
                    n.overrun_error = 1'b1;
                end else begin
                    n.rx_buf  = s.rx9 ? word[7:0] : word[8:1];
                    n.received_ninth_bit    = s.rx9 && word[8];
                    n.rx_full = 1'b1;
                end
                if (!s.continuous_receive_enable) begin
                    n.single_receive_enable = 1'b0;
                end
            end
        end

        // ----------------------------------------------------------
        // Transmitter: one buffer word plus the shifter
        // ----------------------------------------------------------
        last_tx = s.tx9 ? LAST_BIT_NINE : LAST_BIT_EIGHT;
        if (!tx_act) begin
            n.tx_busy = 1'b0;
            n.tx_cnt  = 4'h0;
        end else if (s.tx_busy) begin
            if (fall) begin
                if (s.tx_cnt == last_tx) begin
                    n.tx_busy = 1'b0;
                end else begin
                    n.tx_sh  = {1'b0, s.tx_sh[8:1]};
                    n.tx_cnt = s.tx_cnt + 4'h1;
                end
            end
        end else if (s.tx_full) begin
            n.tx_sh   = {s.transmit_ninth_bit, s.tx_buf};
            n.tx_cnt  = 4'h0;
            n.tx_busy = 1'b1;
            n.tx_full = wr_tx;
        end

        // ----------------------------------------------------------
        // Interrupt and pins, registered
        // ----------------------------------------------------------
        n.irq = n.core[BIT_GLOBAL_IRQ] && n.core[BIT_PERIPH_IRQ]
                && ((n.rx_full && n.ena[BIT_RX_IRQ])
                    || (!n.tx_full && n.ena[BIT_TX_IRQ]));
        n.pins.ck_out  = n.ick ^ n.shift_clk_polarity;
        n.pins.ck_oe_n = !(n.serial_port_enable && n.sync && n.clock_source_select);
        n.pins.dt_out  = n.tx_sh[0];
        n.pins.dt_oe_n = !(n.serial_port_enable && n.sync && n.transmit_enable
                           && !(n.continuous_receive_enable || n.single_receive_enable));
    end

    // --------------------------------------------------------------
    // State register
    // --------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= STATE_RST;
        end else if (ce) begin
            s <= n;
        end
    end

    assign axi_rsp = s.rsp;
    assign pins    = s.pins;
    assign irq     = s.irq;

endmodule

/* rtl/ssr_pkg.sv */
/*
 * Shared constants and types of the clocked serial port block.
 * Assumes an AXI4-Lite master with 8-bit byte addresses.
 */
package ssr_pkg;

    // --------------------------------------------------------------
    // Register byte offsets
    // --------------------------------------------------------------
    localparam logic [7:0] ADDR_RECEIVE_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_RECEIVE_BUFFER         = 8'h04;
    localparam logic [7:0] ADDR_TRANSMIT_STATUS_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_BAUD_CONTROL           = 8'h0C;
    localparam logic [7:0] ADDR_BAUD_DIVISOR_HIGH      = 8'h10;
    localparam logic [7:0] ADDR_BAUD_DIVISOR_LOW       = 8'h14;
    localparam logic [7:0] ADDR_TRANSMIT_BUFFER        = 8'h18;
    localparam logic [7:0] ADDR_IRQ_FLAGS_ONE          = 8'h1C;
    localparam logic [7:0] ADDR_IRQ_ENABLES_ONE        = 8'h20;
    localparam logic [7:0] ADDR_IRQ_PRIORITY_ONE       = 8'h24;
    localparam logic [7:0] ADDR_CORE_INTERRUPT_CONTROL = 8'h28;

    // --------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------
    localparam int BIT_PORT_ENABLE   = 7;
    localparam int BIT_NINE_RX       = 6;
    localparam int BIT_SINGLE_RX     = 5;
    localparam int BIT_CONT_RX       = 4;
    localparam int BIT_FRAMING_ERROR = 2;
    localparam int BIT_OVERRUN_ERROR = 1;
    localparam int BIT_RX_NINTH      = 0;
    localparam int BIT_CLOCK_SOURCE  = 7;
    localparam int BIT_NINE_TX       = 6;
    localparam int BIT_TX_ENABLE     = 5;
    localparam int BIT_SYNC_MODE     = 4;
    localparam int BIT_SHIFTER_EMPTY = 1;
    localparam int BIT_TX_NINTH      = 0;
    localparam int BIT_CLK_POLARITY  = 4;
    localparam int BIT_WIDE_DIVISOR  = 3;
    localparam int BIT_RX_IRQ        = 5;
    localparam int BIT_TX_IRQ        = 4;
    localparam int BIT_GLOBAL_IRQ    = 7;
    localparam int BIT_PERIPH_IRQ    = 6;

    // --------------------------------------------------------------
    // Counts and codes
    // --------------------------------------------------------------
    localparam logic [3:0] LAST_BIT_EIGHT = 4'h7;
    localparam logic [3:0] LAST_BIT_NINE  = 4'h8;
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;

    // --------------------------------------------------------------
    // Carriers
    // --------------------------------------------------------------
    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } ssr_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } ssr_axi_rsp_t;

    typedef struct packed {
        logic ck_out;
        logic ck_oe_n;
        logic dt_out;
        logic dt_oe_n;
    } ssr_pin_t;

    typedef struct packed {
        ssr_axi_rsp_t rsp;
        ssr_pin_t     pins;
        logic         irq;
        logic         aw_got;
        logic [7:0]   aw_addr;
        logic         w_got;
        logic [7:0]   w_data;
        logic         w_lane;
        logic         serial_port_enable;
        logic         rx9;
        logic         single_receive_enable;
        logic         continuous_receive_enable;
        logic         overrun_error;
        logic         received_ninth_bit;
        logic         clock_source_select;
        logic         tx9;
        logic         transmit_enable;
        logic         sync;
        logic         transmit_ninth_bit;
        logic         shift_clk_polarity;
        logic         wide_divisor_select;
        logic [7:0]   div_hi;
        logic [7:0]   div_lo;
        logic [7:0]   ena;
        logic [7:0]   pri;
        logic [7:0]   core;
        logic [7:0]   rx_buf;
        logic         rx_full;
        logic [8:0]   rx_sh;
        logic [3:0]   rx_cnt;
        logic [7:0]   tx_buf;
        logic         tx_full;
        logic [8:0]   tx_sh;
        logic [3:0]   tx_cnt;
        logic         tx_busy;
        logic [15:0]  bcnt;
        logic         ick;
        logic         ck_s1;
        logic         ck_s2;
        logic         dt_s1;
        logic         dt_s2;
        logic         ck_prev;
    } ssr_state_t;

    localparam ssr_pin_t PINS_RST = 4'h5;
    localparam ssr_state_t STATE_RST = '{pins: PINS_RST, default: '0};

endpackage

/* tb/ssr_sva.sv */
/* Checker for the serial port block: bus answers and pin causes.
   Assumes binding to ssr_top with the clock enable held high. */
`timescale 1ns/1ps
module ssr_sva
    import ssr_pkg::*;
(
    input wire logic         aclk,
    input wire logic         aresetn,
    input wire logic         ce,
    input wire ssr_axi_req_t axi_req,
    input wire ssr_axi_rsp_t axi_rsp,
    input wire logic         shift_clk_pin_in,
    input wire logic         serial_data_pin_in,
    input wire ssr_pin_t     pins,
    input wire logic         irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ----------------
    // Helpers
    // ----------------
    logic [3:0] pin_age;
    logic [3:0] bus_age;
    logic       hs;
    assign hs = (axi_req.awvalid && axi_rsp.awready)
             || (axi_req.arvalid && axi_rsp.arready)
             || (axi_rsp.bvalid && axi_req.bready)
             || (axi_rsp.rvalid && axi_req.rready);
    always_ff @(posedge aclk) begin
        if (!aresetn || $changed(shift_clk_pin_in))
            pin_age <= 4'h0;
        else if (pin_age != 4'hF)
            pin_age <= pin_age + 4'h1;
        if (!aresetn || hs)
            bus_age <= 4'h0;
        else if (bus_age != 4'hF)
            bus_age <= bus_age + 4'h1;
    end
    // ----------------
    // Properties
    // ----------------
    a_reset_quiet: assert property ($rose(aresetn) |-> !axi_rsp.awready
        && !axi_rsp.bvalid && !axi_rsp.rvalid && pins.ck_oe_n
        && pins.dt_oe_n && !irq) else $error("outputs busy after reset");
    a_ready_back: assert property ($rose(aresetn) |=> axi_rsp.awready
        && axi_rsp.wready && axi_rsp.arready) else $error("no ready");
    a_read_answer: assert property (axi_req.arvalid && axi_rsp.arready
        |=> axi_rsp.rvalid) else $error("read not answered");
    a_write_answer: assert property (axi_req.awvalid && axi_rsp.awready
        && axi_req.wvalid && axi_rsp.wready |-> ##[1:2] axi_rsp.bvalid)
        else $error("write not answered");
    a_bresp_hold: assert property (axi_rsp.bvalid && !axi_req.bready
        |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
        else $error("write answer dropped");
    a_rdata_hold: assert property (axi_rsp.rvalid && !axi_req.rready
        |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
        else $error("read answer dropped");
    a_irq_fall_cause: assert property (
        $fell(irq) |-> bus_age < 4'h6) else $error("irq fell alone");
    a_slave_dt_cause: assert property (
        pins.ck_oe_n && $changed(pins.dt_out)
        |-> pin_age < 4'h6 || bus_age < 4'h6)
        else $error("data moved without clock");
    cover property ($rose(irq));
    cover property (!pins.ck_oe_n && $changed(pins.ck_out));
    cover property (axi_rsp.rvalid && axi_rsp.rresp == RESP_SLVERR);
endmodule

bind ssr_top ssr_sva i_ssr_sva (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .axi_req(axi_req),
    .axi_rsp(axi_rsp),
    .shift_clk_pin_in(shift_clk_pin_in),
    .serial_data_pin_in(serial_data_pin_in),
    .pins(pins),
    .irq(irq)
);

/* tb/ssr_peer.sv */
/* Serial peer on the shift clock and data lines.
   Assumes the bench resolves both lines from all enables. */
`timescale 1ns/1ps
module ssr_peer (
    input  wire logic       ck,
    input  wire logic       dt,
    input  wire logic       arm,
    input  wire logic [3:0] nbits,
    input  wire logic [8:0] word,
    output logic            ck_drv,
    output logic            dt_drv,
    output logic            dt_en
);
    logic [3:0] idx;
    initial begin
        ck_drv = 1'b0;
        dt_drv = 1'b1;
        dt_en  = 1'b0;
        idx    = 4'h0;
    end
    // New bit on the rise, well away from the sampling fall
    always @(posedge ck) begin
        if (arm) begin
            dt_en  <= 1'b1;
            dt_drv <= word[idx];
            idx    <= (idx == nbits - 4'h1) ? 4'h0 : idx + 4'h1;
        end
    end
    always @(negedge arm) begin
        dt_en <= 1'b0;
        idx   <= 4'h0;
    end
    // Clock only inside frames, idle low; read just before the fall
    task automatic shift_out(input int n, output logic [8:0] got);
        got = '0;
        #7;
        for (int i = 0; i < n; i++) begin
            ck_drv = 1'b1;
            #100;
            got[i] = dt;
            ck_drv = 1'b0;
            #100;
        end
    endtask
endmodule

/* tb/ssr_top_bench.sv */
/* Self-checking bench for the serial port block.
   Assumes the peer model and the bound checker are compiled too. */
`timescale 1ns/1ps
module ssr_top_bench;
    import ssr_pkg::*;
    logic         aclk;
    logic         aresetn;
    logic         ce;
    ssr_axi_req_t req;
    ssr_axi_rsp_t rsp;
    ssr_pin_t     pins;
    logic         irq;
    logic         ck_drv;
    logic         dt_drv;
    logic         dt_en;
    logic         arm;
    logic [3:0]   nbits;
    logic [8:0]   word;
    int           miscompares;
    int           n_compared;
    wire ck_line = !pins.ck_oe_n ? pins.ck_out : ck_drv;
    // Data line has a pull-up
    wire dt_line = !pins.dt_oe_n ? pins.dt_out : dt_en ? dt_drv : 1'b1;
    ssr_top i_ssr_top (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .axi_req(req), .axi_rsp(rsp), .shift_clk_pin_in(ck_line),
        .serial_data_pin_in(dt_line), .pins(pins), .irq(irq));
    ssr_peer i_ssr_peer (.ck(ck_line), .dt(dt_line), .arm(arm),
        .nbits(nbits), .word(word), .ck_drv(ck_drv), .dt_drv(dt_drv),
        .dt_en(dt_en));
    always #12.5 aclk = ~aclk;
    // ----------------
    // Shared tasks
    // ----------------
    task automatic conclude();
        if (miscompares == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic lim(input int k);
        if (k >= 4000) begin
            miscompares++;
            conclude();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int k;
        k = 0;
        req.awvalid <= 1'b1;
        req.awaddr  <= a;
        req.wvalid  <= 1'b1;
        req.wdata   <= {24'h0, d};
        req.wstrb   <= 4'hF;
        req.bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
            k++;
        end while (!rsp.bvalid && k < 4000);
        chk(32'(rsp.bresp), 32'(RESP_OKAY));
        req.bready <= 1'b0;
        @(posedge aclk);
        lim(k);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        int k;
        k = 0;
        req.arvalid <= 1'b1;
        req.araddr  <= a;
        req.rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (rsp.arready) req.arvalid <= 1'b0;
            k++;
        end while (!rsp.rvalid && k < 4000);
        d = rsp.rdata;
        chk(32'(rsp.rresp), 32'(a == 8'hFC ? RESP_SLVERR : RESP_OKAY));
        req.rready <= 1'b0;
        @(posedge aclk);
        lim(k);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(d, exp);
    endtask
    task automatic await_irq(input logic lvl);
        int k;
        k = 0;
        while (irq !== lvl && k < 4000) begin
            @(posedge aclk);
            k++;
        end
        lim(k);
    endtask
    // ----------------
    // Scenarios
    // ----------------
    task automatic t_regs();
        rdc(ADDR_RECEIVE_STATUS_CONTROL, 32'h0);
        rdc(ADDR_IRQ_FLAGS_ONE, 32'h10);
        wr(ADDR_IRQ_FLAGS_ONE, 8'h00);
        rdc(ADDR_IRQ_FLAGS_ONE, 32'h10);
        wr(ADDR_BAUD_DIVISOR_HIGH, 8'hA5);
        rdc(ADDR_BAUD_DIVISOR_HIGH, 32'hA5);
        wr(ADDR_BAUD_DIVISOR_HIGH, 8'h00);
        rdc(8'hFC, 32'h0);
    endtask
    task automatic t_master_single();
        int n;
        n = 0;
        word <= 9'h0A5;
        wr(ADDR_BAUD_DIVISOR_LOW, 8'h03);
        wr(ADDR_TRANSMIT_STATUS_CONTROL, 8'h90);
        wr(ADDR_RECEIVE_STATUS_CONTROL, 8'h80);
        wr(ADDR_IRQ_ENABLES_ONE, 8'h20);
        wr(ADDR_CORE_INTERRUPT_CONTROL, 8'hC0);
        chk(32'(pins.ck_out), 32'h0);
        arm <= 1'b1;
        wr(ADDR_RECEIVE_STATUS_CONTROL, 8'hA0);
        await_irq(1'b1);
        rdc(ADDR_IRQ_FLAGS_ONE, 32'h30);
        rdc(ADDR_RECEIVE_STATUS_CONTROL, 32'h80);
        rdc(ADDR_RECEIVE_BUFFER, 32'hA5);
        await_irq(1'b0);
        arm <= 1'b0;
        repeat (100) begin
            @(posedge aclk);
            if (pins.ck_out !== 1'b0) n++;
        end
        chk(32'(n), 32'h0);
        wr(ADDR_BAUD_CONTROL, 8'h10);
        repeat (3) @(posedge aclk);
        chk(32'(pins.ck_out), 32'h1);
        wr(ADDR_BAUD_CONTROL, 8'h00);
    endtask
    task automatic t_master_cont();
        logic [31:0] d;
        int          k;
        k = 0;
        word  <= 9'h1C3;
        nbits <= 4'h9;
        arm   <= 1'b1;
        wr(ADDR_RECEIVE_STATUS_CONTROL, 8'hF0);
        await_irq(1'b1);
        rd(ADDR_RECEIVE_STATUS_CONTROL, d);
        chk(d & 32'hD3, 32'hD1);
        rdc(ADDR_RECEIVE_BUFFER, 32'hC3);
        await_irq(1'b0);
        await_irq(1'b1);
        do begin
            rd(ADDR_RECEIVE_STATUS_CONTROL, d);
            k++;
        end while (!d[1] && k < 400);
        chk(32'(d[1]), 32'h1);
        wr(ADDR_RECEIVE_STATUS_CONTROL, 8'hC0);
        rd(ADDR_RECEIVE_STATUS_CONTROL, d);
        chk(d & 32'h32, 32'h0);
        rdc(ADDR_RECEIVE_BUFFER, 32'hC3);
        arm   <= 1'b0;
        nbits <= 4'h8;
    endtask
    task automatic t_slave_tx();
        logic [8:0] got;
        wr(ADDR_RECEIVE_STATUS_CONTROL, 8'h80);
        wr(ADDR_TRANSMIT_STATUS_CONTROL, 8'h30);
        wr(ADDR_IRQ_ENABLES_ONE, 8'h10);
        wr(ADDR_TRANSMIT_BUFFER, 8'h3C);
        wr(ADDR_TRANSMIT_BUFFER, 8'h5A);
        rdc(ADDR_IRQ_FLAGS_ONE, 32'h0);
        chk(32'(irq), 32'h0);
        i_ssr_peer.shift_out(8, got);
        @(posedge aclk);
        chk(32'(got), 32'h3C);
        await_irq(1'b1);
        rdc(ADDR_IRQ_FLAGS_ONE, 32'h10);
        i_ssr_peer.shift_out(8, got);
        @(posedge aclk);
        chk(32'(got), 32'h5A);
        wr(ADDR_RECEIVE_STATUS_CONTROL, 8'h90);
        repeat (3) @(posedge aclk);
        chk(32'(pins.dt_oe_n), 32'h1);
        // Nine-bit word: option and ninth bit set before the data
        wr(ADDR_RECEIVE_STATUS_CONTROL, 8'h80);
        wr(ADDR_TRANSMIT_STATUS_CONTROL, 8'h71);
        wr(ADDR_TRANSMIT_BUFFER, 8'h96);
        i_ssr_peer.shift_out(9, got);
        @(posedge aclk);
        chk(32'(got), 32'h196);
    endtask
    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        ce = 1'b1;
        req = '0;
        arm = 1'b0;
        word = 9'h0;
        nbits = 4'h8;
        miscompares = 0;
        n_compared = 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_master_single();
        t_master_cont();
        t_slave_tx();
        conclude();
    end
endmodule
